// ===== design/clfc_controller.sv
`timescale 1ns/1ps
`default_nettype none
module clfc_controller #(
  parameter clfc_pkg::clfc_mode_t MODE = clfc_pkg::CLFC_MODE_AUTORETRY,
  parameter logic EN_ACTIVE_HIGH = clfc_pkg::CLFC_EN_ACTIVE_HIGH,
  parameter int unsigned BLANK_CYCLES = clfc_pkg::CLFC_BLANK_CYCLES,
  parameter int unsigned RETRY_RATIO = clfc_pkg::CLFC_RETRY_RATIO
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic enable_pin,
  input wire clfc_pkg::clfc_det_t detect,
  output logic switch_on,
  output logic current_limiting,
  output logic fault_n_out,
  output logic fault_n_oe
);

  localparam int unsigned TW = 32;
  localparam logic [TW-1:0] BLANK_LIMIT = TW'(BLANK_CYCLES);
  localparam logic [TW-1:0] RETRY_LIMIT = TW'(BLANK_CYCLES * RETRY_RATIO);

  typedef enum logic [2:0] {
    CLFC_ST_OFF,
    CLFC_ST_ON,
    CLFC_ST_BLANK,
    CLFC_ST_RETRY,
    CLFC_ST_LATCHED,
    CLFC_ST_LIMIT
  } clfc_state_t;

  clfc_pkg::clfc_det_t det_s;
  logic en_s;
  logic en_prev_q;
  logic en_on;
  logic en_toggled;
  logic thermal_q;
  logic reverse_q;
  logic oc_fault;
  logic blank_run;
  logic blank_done;
  logic retry_run;
  logic retry_done;
  logic block_off;
  clfc_state_t state_q;
  clfc_state_t state_d;

  // Two-stage capture on every detector and the enable
  clfc_sync #(.WIDTH($bits(clfc_pkg::clfc_det_t) + 1)) u_sync (
    .clock(clock),
    .reset(reset),
    .din({detect, enable_pin}),
    .dout({det_s, en_s})
  );

  assign en_on = EN_ACTIVE_HIGH ? en_s : !en_s;

  always_ff @(posedge clock) begin
    if (reset) begin
      en_prev_q <= 1'h0;
    end else begin
      en_prev_q <= en_on;
    end
  end

  // A falling edge of the effective enable ends the latched state
  assign en_toggled = en_prev_q && !en_on;

  // Thermal shutdown holds until the sensor reports the hysteresis drop
  always_ff @(posedge clock) begin
    if (reset) begin
      thermal_q <= 1'h0;
    end else if (det_s.over_temp) begin
      thermal_q <= 1'h1;
    end else if (det_s.temp_cleared) begin
      thermal_q <= 1'h0;
    end
  end

  // Reverse trip follows the detector; release when reverse voltage ends
  always_ff @(posedge clock) begin
    if (reset) begin
      reverse_q <= 1'h0;
    end else begin
      reverse_q <= det_s.reverse_trip;
    end
  end

  assign block_off = thermal_q || det_s.over_temp || reverse_q || det_s.reverse_trip
    || det_s.limit_set_short;

  assign blank_run = (state_q == CLFC_ST_BLANK) && det_s.overcurrent;
  assign retry_run = (state_q == CLFC_ST_RETRY);

  clfc_timer #(.WIDTH(TW)) u_blank (
    .clock(clock),
    .reset(reset),
    .run(blank_run),
    .limit(BLANK_LIMIT),
    .done(blank_done)
  );

  clfc_timer #(.WIDTH(TW)) u_retry (
    .clock(clock),
    .reset(reset),
    .run(retry_run),
    .limit(RETRY_LIMIT),
    .done(retry_done)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      CLFC_ST_OFF: begin
        if (en_on && !block_off) begin
          state_d = CLFC_ST_ON;
        end
      end
      CLFC_ST_ON: begin
        if (!en_on || block_off) begin
          state_d = CLFC_ST_OFF;
        end else if (det_s.overcurrent) begin
          state_d = CLFC_ST_BLANK;
        end
      end
      CLFC_ST_BLANK: begin
        if (!en_on || block_off) begin
          state_d = CLFC_ST_OFF;
        end else if (!det_s.overcurrent) begin
          state_d = CLFC_ST_ON;
        end else if (blank_done && det_s.drop_above) begin
          case (MODE)
            clfc_pkg::CLFC_MODE_AUTORETRY: state_d = CLFC_ST_RETRY;
            clfc_pkg::CLFC_MODE_LATCHOFF: state_d = CLFC_ST_LATCHED;
            default: state_d = CLFC_ST_LIMIT;
          endcase
        end
      end
      CLFC_ST_RETRY: begin
        if (!en_on || block_off) begin
          state_d = CLFC_ST_OFF;
        end else if (retry_done) begin
          state_d = det_s.overcurrent ? CLFC_ST_BLANK : CLFC_ST_ON;
        end
      end
      CLFC_ST_LATCHED: begin
        if (en_toggled) begin
          state_d = CLFC_ST_OFF;
        end
      end
      CLFC_ST_LIMIT: begin
        if (!en_on || block_off) begin
          state_d = CLFC_ST_OFF;
        end else if (!det_s.overcurrent) begin
          state_d = CLFC_ST_ON;
        end
      end
      default: state_d = CLFC_ST_OFF;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= CLFC_ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Flag holds through blank after a retry, so it never blinks during autoretry
  logic retry_flag_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      retry_flag_q <= 1'h0;
    end else if (state_d == CLFC_ST_RETRY) begin
      retry_flag_q <= 1'h1;
    end else if (state_d != CLFC_ST_BLANK) begin
      retry_flag_q <= 1'h0;
    end
  end

  assign oc_fault = (state_d == CLFC_ST_RETRY) || (state_d == CLFC_ST_LATCHED)
    || (state_d == CLFC_ST_LIMIT) || ((state_d == CLFC_ST_BLANK) && retry_flag_q);

  always_ff @(posedge clock) begin
    if (reset) begin
      switch_on <= 1'h0;
      current_limiting <= 1'h0;
      fault_n_out <= 1'h0;
      fault_n_oe <= 1'h0;
    end else begin
      switch_on <= (state_d == CLFC_ST_ON) || (state_d == CLFC_ST_BLANK)
        || (state_d == CLFC_ST_LIMIT);
      current_limiting <= (state_d == CLFC_ST_BLANK) || (state_d == CLFC_ST_LIMIT);
      fault_n_out <= 1'h0;
      fault_n_oe <= oc_fault || block_off;
    end
  end

endmodule : clfc_controller
`default_nettype wire

// ===== design/clfc_pkg.sv
package clfc_pkg;

  // Overcurrent response variants
  typedef enum logic [1:0] {
    CLFC_MODE_AUTORETRY,
    CLFC_MODE_LATCHOFF,
    CLFC_MODE_CONTINUOUS
  } clfc_mode_t;

  // Blanking interval, nominal, in microseconds
  localparam int unsigned CLFC_BLANK_US = 15000;
  localparam int unsigned CLFC_BLANK_MIN_US = 10000;
  localparam int unsigned CLFC_BLANK_MAX_US = 25000;
  localparam int unsigned CLFC_CLOCK_MHZ = 25;
  localparam int unsigned CLFC_BLANK_CYCLES = CLFC_BLANK_US * CLFC_CLOCK_MHZ;
  localparam int unsigned CLFC_RETRY_RATIO = 32;

  // Thermal thresholds in degrees C, for reference by the analog sensor
  localparam int unsigned CLFC_TSHUT_C = 160;
  localparam int unsigned CLFC_THYST_C = 20;

  localparam logic CLFC_EN_ACTIVE_HIGH = 1'h1;

  // Detector levels, bundled
  typedef struct packed {
    logic overcurrent;
    logic drop_above;
    logic reverse_trip;
    logic over_temp;
    logic temp_cleared;
    logic limit_set_short;
  } clfc_det_t;

  localparam clfc_det_t CLFC_DET_IDLE = '{default: 1'h0};

endpackage : clfc_pkg

// ===== design/clfc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module clfc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule : clfc_sync
`default_nettype wire

// ===== design/clfc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module clfc_timer #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  input wire logic [WIDTH-1:0] limit,
  output logic done
);

  // Counts while run is held; done is high in the last of limit cycles
  // Done is not registered, so the caller's state changes exactly limit cycles after run rose
  logic [WIDTH-1:0] count_q;

  always_ff @(posedge clock) begin
    if (reset || !run) begin
      count_q <= '0;
    end else if (count_q == limit - {{(WIDTH-1){1'h0}}, 1'h1}) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + {{(WIDTH-1){1'h0}}, 1'h1};
    end
  end

  assign done = run && (count_q == limit - {{(WIDTH-1){1'h0}}, 1'h1});

endmodule : clfc_timer
`default_nettype wire

// ===== tb/clfc_sva.sv
`timescale 1ns/1ps
`default_nettype none
module clfc_sva #(
  parameter int unsigned BLANK_CYCLES = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic enable_pin,
  input wire clfc_pkg::clfc_det_t detect,
  input wire logic switch_on,
  input wire logic current_limiting,
  input wire logic fault_n_out,
  input wire logic fault_n_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  int oc_q;
  wire logic other = detect.reverse_trip | detect.over_temp | detect.limit_set_short;
  always_ff @(posedge clock) begin
    if (reset) begin
      oc_q <= 0;
    end else begin
      oc_q <= detect.overcurrent ? oc_q + 1 : 0;
    end
  end
  sequence s_off_flag;
    !switch_on && fault_n_oe;
  endsequence
  property p_drain; fault_n_out == 1'h0; endproperty
  property p_temp; $rose(detect.over_temp) |-> ##[1:4] s_off_flag; endproperty
  property p_rev; $rose(detect.reverse_trip) |-> ##[1:4] s_off_flag; endproperty
  property p_short; $rose(detect.limit_set_short) |-> ##[1:4] s_off_flag; endproperty
  property p_en; !enable_pin [*4] |-> !switch_on; endproperty
  property p_blank; $rose(fault_n_oe) && !other |-> oc_q >= BLANK_CYCLES; endproperty
  property p_retry; $fell(switch_on) && fault_n_oe && !other |-> !switch_on [*8]; endproperty
  property p_hold; $fell(fault_n_oe) |-> !$past(detect.overcurrent, 3); endproperty
  a_drain: assert property (p_drain) else $error("fault line driven high");
  a_temp: assert property (p_temp) else $error("no thermal shutdown");
  a_rev: assert property (p_rev) else $error("no reverse trip");
  a_short: assert property (p_short) else $error("no limit short response");
  a_en: assert property (p_en) else $error("switch on while disabled");
  a_blank: assert property (p_blank) else $error("flag before blanking");
  a_retry: assert property (p_retry) else $error("retry too short");
  a_hold: assert property (p_hold) else $error("flag released in fault");
endmodule : clfc_sva
`default_nettype wire

// ===== tb/clfc_host.sv
`timescale 1ns/1ps
`default_nettype none
module clfc_host (
  input wire logic clock,
  input wire logic en_req,
  input wire logic fault_n_out,
  input wire logic fault_n_oe,
  output var logic enable_pin,
  output logic flag_wire
);
  // Enable only moves on a clock edge, like a processor port
  always @(posedge clock) enable_pin <= en_req;
  // Pull-up shows the released level
  assign flag_wire = fault_n_oe ? fault_n_out : 1'h1;
endmodule : clfc_host
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned BLANK = 8;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic en_req = 1'h0;
  logic enable_pin, switch_on, current_limiting, fault_n_out, fault_n_oe, flag_wire;
  clfc_pkg::clfc_det_t det = clfc_pkg::CLFC_DET_IDLE;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  initial forever #20 clock = ~clock;
  clfc_host u_host (.clock, .en_req, .fault_n_out, .fault_n_oe, .enable_pin, .flag_wire);
  clfc_controller #(.BLANK_CYCLES(BLANK)) u_dut (.clock, .reset, .enable_pin,
    .detect(det), .switch_on, .current_limiting, .fault_n_out, .fault_n_oe);
  task automatic close_out();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge clock);
  endtask : step
  // Pre-edge values are read, so no race with the design's updates
  task automatic wait_st(input logic [1:0] exp, input int lim);
    for (int i = 0; i < lim && {switch_on, flag_wire} !== exp; i++) step(1);
    chk({switch_on, flag_wire}, exp);
  endtask : wait_st
  task automatic t_retry();
    det.overcurrent <= 1'h1;
    det.drop_above <= 1'h1;
    step(BLANK - 2);
    det.overcurrent <= 1'h0;
    step(BLANK + 6);
    chk({switch_on, flag_wire}, 2'h3);
    det.overcurrent <= 1'h1;
    wait_st(2'h0, BLANK + 8);
    n = 0;
    while (switch_on !== 1'h1 && n < 400) begin
      chk({switch_on, flag_wire}, 2'h0);
      step(1);
      n++;
    end
    chk(n, BLANK * 32);
    chk({switch_on, flag_wire}, 2'h2);
    chk(current_limiting, 1'h1);
    wait_st(2'h0, BLANK + 8);
    wait_st(2'h2, 300);
    det.overcurrent <= 1'h0;
    wait_st(2'h3, BLANK + 8);
    step(20);
    chk({switch_on, flag_wire}, 2'h3);
    chk(current_limiting, 1'h0);
  endtask : t_retry
  task automatic t_thermal();
    det.over_temp <= 1'h1;
    step(5);
    chk({switch_on, flag_wire}, 2'h0);
    det.over_temp <= 1'h0;
    step(10);
    chk({switch_on, flag_wire}, 2'h0);
    det.temp_cleared <= 1'h1;
    wait_st(2'h3, 8);
    det.temp_cleared <= 1'h0;
  endtask : t_thermal
  task automatic t_trip();
    det.reverse_trip <= 1'h1;
    step(5);
    chk({switch_on, flag_wire}, 2'h0);
    det.reverse_trip <= 1'h0;
    wait_st(2'h3, 8);
    det.limit_set_short <= 1'h1;
    step(5);
    chk({switch_on, flag_wire}, 2'h0);
    det.limit_set_short <= 1'h0;
    wait_st(2'h3, 8);
  endtask : t_trip
  always @(posedge clock) begin
    cyc++;
    if (cyc > 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    step(3);
    reset <= 1'h0;
    step(5);
    chk({switch_on, flag_wire}, 2'h1);
    en_req <= 1'h1;
    step(6);
    chk({switch_on, flag_wire}, 2'h3);
    t_retry();
    t_thermal();
    t_trip();
    close_out();
  end
endmodule : tb_top
bind clfc_controller clfc_sva #(.BLANK_CYCLES(BLANK_CYCLES)) u_sva (.clock, .reset,
  .enable_pin, .detect, .switch_on, .current_limiting, .fault_n_out, .fault_n_oe);
`default_nettype wire
